// ### src/ppm_port.sv
// top: two-port pin configuration, data latches and match comparator
`timescale 1ns/100ps
`default_nettype none
module ppm_port
    import ppm_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic sfr_rmw,
    output logic [7:0] sfr_rdata,
    // first port pins
    input wire logic [WIDTH-1:0] port_one_in,
    output logic [WIDTH-1:0] port_one_out,
    output logic [WIDTH-1:0] port_one_oe_n,
    // second port pins
    input wire logic [WIDTH-1:0] port_two_in,
    output logic [WIDTH-1:0] port_two_out,
    output logic [WIDTH-1:0] port_two_oe_n,
    // crossbar and analog controls
    output logic [WIDTH-1:0] port1_skip,
    output logic [WIDTH-1:0] port2_skip,
    output logic [WIDTH-1:0] port1_analog_n,
    output logic [WIDTH-1:0] port2_analog_n,
    // match event
    input wire logic match_irq_enable,
    output logic match_event,
    output logic match_irq,
    output logic osc_wake
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] p1_data_q; // first port latch
    logic [7:0] p2_data_q; // second port latch
    logic [7:0] p1_style_q; // first port output style
    logic [7:0] p2_style_q; // second port output style, bit 0 only
    logic [7:0] p1_mask_q; // compare mask
    logic [7:0] p1_value_q; // compare value
    logic [7:0] p1_bypass_q; // crossbar skip, port one
    logic [7:0] p2_bypass_q; // crossbar skip, port two
    logic [7:0] p1_analog_q; // input mode, port one (0 = analog)
    logic [7:0] p2_analog_q; // input mode, port two
    logic [7:0] p1_lvl; // synchronized pins
    logic [7:0] p2_lvl;
    logic [7:0] p1_drv;
    logic [7:0] p1_oen;
    logic [7:0] p2_drv;
    logic [7:0] p2_oen;
    logic match_d; // comparator result
    logic [7:0] rdata_d;

    initial
    begin
        if (WIDTH != 8) $error("ppm_port: port width must be 8");
    end

    // ----------------------------------------
    // synchronizers
    // ----------------------------------------
    ppm_sync #(.WIDTH(WIDTH)) u_sync1
    (
        .clk(clk),
        .resetn(resetn),
        .raw_i(port_one_in),
        .level_o(p1_lvl)
    );
    ppm_sync #(.WIDTH(WIDTH)) u_sync2
    (
        .clk(clk),
        .resetn(resetn),
        .raw_i(port_two_in),
        .level_o(p2_lvl)
    );

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    // data latches: byte writes; bit ops arrive as a latch-based rmw byte
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            p1_data_q <= PPM_RST_DATA;
            p2_data_q <= PPM_RST_DATA; // [R10]
        end
        else if (sfr_wr)
        begin
            if (sfr_addr == PPM_ADDR_P1_DATA)
                p1_data_q <= sfr_wdata; // [R11]
            if (sfr_addr == PPM_ADDR_P2_DATA)
                p2_data_q <= sfr_wdata; // [R8] [R10]
        end
    end

    // pin configuration registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            p1_style_q <= PPM_RST_STYLE; // [R2]
            p2_style_q <= PPM_RST_STYLE;
            p1_bypass_q <= PPM_RST_BYPASS; // [R4]
            p2_bypass_q <= PPM_RST_BYPASS;
            p1_analog_q <= PPM_RST_ANALOG; // [R1]
            p2_analog_q <= PPM_RST_ANALOG;
        end
        else if (sfr_wr)
        begin
            unique case (sfr_addr)
                PPM_ADDR_P1_STYLE: p1_style_q <= sfr_wdata;
                PPM_ADDR_P2_STYLE: p2_style_q <= sfr_wdata & PPM_P2_STYLE_WMASK; // [R15]
                PPM_ADDR_P1_BYPASS: p1_bypass_q <= sfr_wdata; // [R4]
                PPM_ADDR_P2_BYPASS: p2_bypass_q <= sfr_wdata;
                PPM_ADDR_P1_ANALOG: p1_analog_q <= sfr_wdata; // [R1]
                PPM_ADDR_P2_ANALOG: p2_analog_q <= sfr_wdata;
                default: ; // other addresses belong to other blocks
            endcase
        end
    end

    // comparator registers
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            p1_mask_q <= PPM_RST_MASK; // [R7]
            p1_value_q <= PPM_RST_VALUE;
        end
        else if (sfr_wr)
        begin
            if (sfr_addr == PPM_ADDR_P1_MASK)
                p1_mask_q <= sfr_wdata; // [R7]
            if (sfr_addr == PPM_ADDR_P1_VALUE)
                p1_value_q <= sfr_wdata; // [R6]
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // pin reads mask analog pins; rmw reads return the latch instead
    always_comb
    begin
        rdata_d = 8'h00;
        unique case (sfr_addr)
            PPM_ADDR_P1_DATA: rdata_d = sfr_rmw ? p1_data_q : (p1_lvl & p1_analog_q); // [R13]
            PPM_ADDR_P2_DATA: rdata_d = sfr_rmw ? p2_data_q : (p2_lvl & p2_analog_q); // [R9] [R13]
            PPM_ADDR_P1_STYLE: rdata_d = p1_style_q;
            PPM_ADDR_P2_STYLE: rdata_d = p2_style_q; // [R15]
            PPM_ADDR_P1_MASK: rdata_d = p1_mask_q;
            PPM_ADDR_P1_VALUE: rdata_d = p1_value_q;
            PPM_ADDR_P1_BYPASS: rdata_d = p1_bypass_q;
            PPM_ADDR_P2_BYPASS: rdata_d = p2_bypass_q;
            PPM_ADDR_P1_ANALOG: rdata_d = p1_analog_q;
            PPM_ADDR_P2_ANALOG: rdata_d = p2_analog_q;
            default: rdata_d = 8'h00; // unmapped reads as zero
        endcase
    end

    // read data registered, one cycle after the strobe
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            sfr_rdata <= 8'h00;
        else if (sfr_rd)
            sfr_rdata <= rdata_d;
    end

    // ----------------------------------------
    // match comparator
    // ----------------------------------------
    // mismatch of masked pins; an analog pin reads 0 like the data path
    assign match_d = ((p1_lvl & p1_analog_q & p1_mask_q) != (p1_value_q & p1_mask_q)); // [R6] [R7]

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            match_event <= 1'b0;
            match_irq <= 1'b0;
            osc_wake <= 1'b0;
        end
        else
        begin
            match_event <= match_d; // [R6]
            match_irq <= match_d & match_irq_enable; // [R12]
            osc_wake <= match_d; // [R12] wake regardless of enable
        end
    end

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    ppm_pad #(.WIDTH(WIDTH)) u_pad1
    (
        .latch_i(p1_data_q),
        .digital_i(p1_analog_q),
        .pushpull_i(p1_style_q),
        .pin_o(p1_drv),
        .pin_oe_n(p1_oen)
    );
    ppm_pad #(.WIDTH(WIDTH)) u_pad2
    (
        .latch_i(p2_data_q),
        .digital_i(p2_analog_q),
        .pushpull_i(p2_style_q),
        .pin_o(p2_drv),
        .pin_oe_n(p2_oen)
    );

    // outputs registered so the pads see glitch-free levels
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            port_one_out <= '1;
            port_one_oe_n <= '1;
            port_two_out <= '1;
            port_two_oe_n <= '1;
            port1_skip <= '0;
            port2_skip <= '0;
            port1_analog_n <= '1;
            port2_analog_n <= '1;
        end
        else
        begin
            port_one_out <= p1_drv; // [R11]
            port_one_oe_n <= p1_oen; // [R1] [R3]
            port_two_out <= p2_drv; // [R8]
            port_two_oe_n <= p2_oen;
            port1_skip <= p1_bypass_q; // [R4]
            port2_skip <= p2_bypass_q;
            port1_analog_n <= p1_analog_q; // [R1]
            port2_analog_n <= p2_analog_q;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    analog_nodrive_a: assert property (@(posedge clk) disable iff (!resetn)
        (!p1_analog_q[0]) |=> port_one_oe_n[0]) else $error("analog pin driven"); // [R1]
    opendrain_float_a: assert property (@(posedge clk) disable iff (!resetn)
        (p2_analog_q[0] && p2_data_q[0] && !p2_style_q[0]) |=> port_two_oe_n[0])
        else $error("open-drain one drove"); // [R2]
    style_ignored_a: assert property (@(posedge clk) disable iff (!resetn)
        (!p1_analog_q[1] && p1_style_q[1]) |=> port_one_oe_n[1]) else $error("style used on analog"); // [R3]
    skip_follow_a: assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> (port1_skip == $past(p1_bypass_q))) else $error("skip mismatch"); // [R4]
    match_raise_a: assert property (@(posedge clk) disable iff (!resetn)
        match_d |=> match_event && osc_wake) else $error("match not raised"); // [R6]
    mask_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        (p1_mask_q == 8'h00) |=> !match_event) else $error("masked match fired"); // [R7]
    drive_low_a: assert property (@(posedge clk) disable iff (!resetn)
        (p2_analog_q[0] && !p2_data_q[0]) |=> (!port_two_oe_n[0] && !port_two_out[0]))
        else $error("zero not driven low"); // [R8]
    analog_read_a: assert property (@(posedge clk) disable iff (!resetn)
        (sfr_rd && !sfr_rmw && sfr_addr == PPM_ADDR_P2_DATA && !p2_analog_q[2]) |=> !sfr_rdata[2])
        else $error("analog bit read one"); // [R9]
    rmw_latch_a: assert property (@(posedge clk) disable iff (!resetn)
        (sfr_rd && sfr_rmw && sfr_addr == PPM_ADDR_P1_DATA) |=> (sfr_rdata == $past(p1_data_q)))
        else $error("rmw read not latch"); // [R13]
    irq_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        match_irq |-> match_event) else $error("irq without match"); // [R12]
    style_bits_a: assert property (@(posedge clk) disable iff (!resetn)
        p2_style_q[7:1] == 7'h00) else $error("p2 style upper bits set"); // [R15]
    drive_one_a: assert property (@(posedge clk) disable iff (!resetn)
        (p1_analog_q[0] && !p1_data_q[0]) |=> !port_one_oe_n[0]) else $error("p1 zero undriven"); // [R11]

    match_seen_c: cover property (@(posedge clk) disable iff (!resetn) match_irq);
    rmw_seen_c: cover property (@(posedge clk) disable iff (!resetn) sfr_rd && sfr_rmw);
    pushpull_c: cover property (@(posedge clk) disable iff (!resetn) p2_style_q[0] && p2_data_q[0]);
endmodule : ppm_port
`default_nettype wire

// ### inc/ppm_pkg.sv
// package: register map, reset values and widths for the port pin config and match block
// Function
// [R1] input-mode 0 makes pin analog, disables digital
// [R2] output-mode 0 open-drain, 1 push-pull, reset 0
// [R3] output-mode ignored while pin is analog
// [R4] skip bit 1 hides pin from crossbar
// [R5] software should skip analog and special pins
// [R6] match event when masked pins differ from value
// [R7] mask bit 0 excludes pin, mask resets zero
// [R8] port two latch drives pins, 1 may float
// [R9] port two read: analog 0, else pin level
// [R10] port two latch resets ones, bit access
// [R11] port one latch drives pins the same way
// [R12] match event requests interrupt and wakes oscillator
// [R13] read-modify-write reads latch, not pin
// [R14] pins pass synchronizer before reads and compare
// [R15] port two output-mode: only bit 0 writable
package ppm_pkg;
    // ----------------------------------------
    // register addresses
    // ----------------------------------------
    localparam logic [7:0] PPM_ADDR_P1_DATA = 8'h90;
    localparam logic [7:0] PPM_ADDR_P2_DATA = 8'hA0;
    localparam logic [7:0] PPM_ADDR_P1_STYLE = 8'hA5;
    localparam logic [7:0] PPM_ADDR_P2_STYLE = 8'hA6;
    localparam logic [7:0] PPM_ADDR_P1_MASK = 8'hBF;
    localparam logic [7:0] PPM_ADDR_P1_VALUE = 8'hCF;
    localparam logic [7:0] PPM_ADDR_P1_BYPASS = 8'hD5;
    localparam logic [7:0] PPM_ADDR_P2_BYPASS = 8'hD6;
    localparam logic [7:0] PPM_ADDR_P1_ANALOG = 8'hF2;
    localparam logic [7:0] PPM_ADDR_P2_ANALOG = 8'hF3;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] PPM_RST_DATA = 8'hFF;
    localparam logic [7:0] PPM_RST_STYLE = 8'h00;
    localparam logic [7:0] PPM_RST_MASK = 8'h00;
    localparam logic [7:0] PPM_RST_VALUE = 8'hFF;
    localparam logic [7:0] PPM_RST_BYPASS = 8'h00;
    localparam logic [7:0] PPM_RST_ANALOG = 8'hFF;
    // writable bits of port two output style
    localparam logic [7:0] PPM_P2_STYLE_WMASK = 8'h01;
    localparam int PPM_WIDTH = 8;
endpackage : ppm_pkg

// ### src/ppm_sync.sv
// three-stage pin synchronizer with second/third agreement filter
`timescale 1ns/100ps
`default_nettype none
module ppm_sync
    import ppm_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // raw and filtered levels
    input wire logic [WIDTH-1:0] raw_i,
    output logic [WIDTH-1:0] level_o
);
    // ----------------------------------------
    // stages
    // ----------------------------------------
    logic [WIDTH-1:0] s1_q; // metastability catcher, read only by s2
    logic [WIDTH-1:0] s2_q; // second stage
    logic [WIDTH-1:0] s3_q; // third stage

    initial
    begin
        if (WIDTH < 1) $error("ppm_sync: width must be positive");
    end

    // shift chain; pins reset high as the weak pullups would pull them
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end
        else
        begin
            s1_q <= raw_i; // [R14]
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accept a new level per bit only when stages two and three agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_filt
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                    level_o[g] <= 1'b1;
                else if (s2_q[g] == s3_q[g])
                    level_o[g] <= s3_q[g]; // [R14]
            end
        end
    endgenerate
endmodule : ppm_sync
`default_nettype wire

// ### src/ppm_pad.sv
// per-pin output driver selection for one port
`timescale 1ns/100ps
`default_nettype none
module ppm_pad
    import ppm_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // configuration
    input wire logic [WIDTH-1:0] latch_i,
    input wire logic [WIDTH-1:0] digital_i,
    input wire logic [WIDTH-1:0] pushpull_i,
    // pin drive, enable active low
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe_n
);
    // ----------------------------------------
    // driver decode
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_pin
            always_comb
            begin
                pin_o[g] = latch_i[g];
                // analog pins never drive; style bit is don't-care there
                if (!digital_i[g])
                    pin_oe_n[g] = 1'b1; // [R1] [R3]
                else if (!latch_i[g])
                    pin_oe_n[g] = 1'b0; // [R8] [R11]
                else
                    pin_oe_n[g] = ~pushpull_i[g]; // [R2] open-drain floats a one
            end
        end
    endgenerate
endmodule : ppm_pad
`default_nettype wire

// ### bench/ppm_pins.sv
// external pin model: resolves device drive, outside driver, pullup and floating pins
`timescale 1ns/100ps
`default_nettype none
module ppm_pins
    import ppm_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // clock
    input wire logic clk,
    // device side
    input wire logic [WIDTH-1:0] pin_o,
    input wire logic [WIDTH-1:0] pin_oe_n,
    input wire logic [WIDTH-1:0] digital,
    // outside driver
    input wire logic [WIDTH-1:0] ext_val,
    input wire logic [WIDTH-1:0] ext_en,
    // resolved level
    output logic [WIDTH-1:0] level
);
    // flips every cycle so an undriven analog pin never keeps a value
    // plain always here: a declaration initialiser next to always_ff is refused by strict tools
    logic [WIDTH-1:0] float_q = '0;
    always @(posedge clk)
    begin
        float_q <= ~float_q;
    end
    // device drive wins, then the outside driver, then the weak pullup
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            if (!pin_oe_n[i])
                level[i] = pin_o[i];
            else if (ext_en[i])
                level[i] = ext_val[i];
            else if (digital[i])
                level[i] = 1'b1; // pullup only on digital pins
            else
                level[i] = float_q[i]; // analog pin floats
        end
    end
endmodule : ppm_pins
`default_nettype wire

// ### bench/ppm_port_tb.sv
// testbench: register access, pin drive, read-back and match checks for the port block
`timescale 1ns/100ps
`default_nettype none
module ppm_port_tb
    import ppm_pkg::*;
;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clk, resetn, sfr_wr, sfr_rd, sfr_rmw, match_irq_enable, match_event, match_irq, osc_wake;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, p1_in, p1_out, p1_oe_n, p2_in, p2_out, p2_oe_n;
    logic [7:0] port1_skip, port2_skip, port1_analog_n, port2_analog_n, ext1, ext1_en, ext2, ext2_en;
    int failures, checks;
    // register map in table order, with reset values
    logic [7:0] addr_t [10] = '{PPM_ADDR_P1_DATA, PPM_ADDR_P2_DATA, PPM_ADDR_P1_STYLE, PPM_ADDR_P2_STYLE,
        PPM_ADDR_P1_MASK, PPM_ADDR_P1_VALUE, PPM_ADDR_P1_BYPASS, PPM_ADDR_P2_BYPASS, PPM_ADDR_P1_ANALOG,
        PPM_ADDR_P2_ANALOG};
    logic [7:0] rst_t [10] = '{PPM_RST_DATA, PPM_RST_DATA, PPM_RST_STYLE, PPM_RST_STYLE, PPM_RST_MASK,
        PPM_RST_VALUE, PPM_RST_BYPASS, PPM_RST_BYPASS, PPM_RST_ANALOG, PPM_RST_ANALOG};
    // ----------------------------------------
    // design and pin models
    // ----------------------------------------
    ppm_port #(.WIDTH(8)) ppm_port_inst (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rmw(sfr_rmw), .sfr_rdata(sfr_rdata),
        .port_one_in(p1_in), .port_one_out(p1_out), .port_one_oe_n(p1_oe_n), .port_two_in(p2_in),
        .port_two_out(p2_out), .port_two_oe_n(p2_oe_n), .port1_skip(port1_skip), .port2_skip(port2_skip),
        .port1_analog_n(port1_analog_n), .port2_analog_n(port2_analog_n),
        .match_irq_enable(match_irq_enable), .match_event(match_event), .match_irq(match_irq),
        .osc_wake(osc_wake));
    ppm_pins #(.WIDTH(8)) pins_one (.clk(clk), .pin_o(p1_out), .pin_oe_n(p1_oe_n),
        .digital(port1_analog_n), .ext_val(ext1), .ext_en(ext1_en), .level(p1_in));
    ppm_pins #(.WIDTH(8)) pins_two (.clk(clk), .pin_o(p2_out), .pin_oe_n(p2_oe_n),
        .digital(port2_analog_n), .ext_val(ext2), .ext_en(ext2_en), .level(p2_in));
    // ----------------------------------------
    // clock and watchdog
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // the tests need well under 3000 cycles
    initial
    begin
        #(40 * 6000);
        failures++;
        print_verdict();
    end
    // ----------------------------------------
    // tasks and expectations
    // ----------------------------------------
    // drive enable expected: low when digital and (latch low or push-pull)
    function automatic logic [7:0] exp_oe(input logic [7:0] lat, dig, pp);
        return ~(dig & (~lat | pp));
    endfunction : exp_oe
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit
    // strobe held across one rising edge, released at the next falling edge
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] w);
        @(negedge clk);
        sfr_addr = a;
        sfr_wdata = w;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask : sfr_write
    task automatic sfr_read(input logic [7:0] a, input logic rmw, output logic [7:0] r);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        sfr_rmw = rmw;
        @(negedge clk);
        sfr_rd = 1'b0;
        sfr_rmw = 1'b0;
        r = sfr_rdata;
    endtask : sfr_read
    // software skips every analog pin
    task automatic cfg(input int p, input logic [7:0] lat, sty, dig);
        sfr_write(p ? PPM_ADDR_P2_DATA : PPM_ADDR_P1_DATA, lat);
        sfr_write(p ? PPM_ADDR_P2_STYLE : PPM_ADDR_P1_STYLE, sty);
        sfr_write(p ? PPM_ADDR_P2_ANALOG : PPM_ADDR_P1_ANALOG, dig);
        sfr_write(p ? PPM_ADDR_P2_BYPASS : PPM_ADDR_P1_BYPASS, ~dig);
    endtask : cfg
    task automatic do_reset;
        logic [7:0] r;
        @(negedge clk);
        resetn = 1'b0;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            sfr_read(addr_t[i], 1'b1, r);
            chk_byte(r, rst_t[i]);
        end
        chk_byte(p2_oe_n, 8'hFF);
        chk_byte(port1_analog_n, PPM_RST_ANALOG);
        chk_bit(match_event, 1'b0);
    endtask : do_reset
    task print_verdict;
        $display("failures=%0d checks=%0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] d, lat, sty, es, dig, eoe, w, mask, val, prev, dig1;
        int p;
        logic em;
        {resetn, sfr_wr, sfr_rd, sfr_rmw, match_irq_enable} = '0;
        {sfr_addr, sfr_wdata, ext1, ext1_en, ext2, ext2_en} = '0;
        failures = 0;
        checks = 0;
        p = $urandom(8);
        do_reset();
        // every register takes all-ones, then two random bytes; only bit 0 of port two style sticks
        for (int k = 0; k < 3; k++)
            for (int i = 0; i < 10; i++)
            begin
                w = (k == 0) ? 8'hFF : 8'($urandom);
                sfr_write(addr_t[i], w);
                sfr_read(addr_t[i], 1'b1, d);
                chk_byte(d, (addr_t[i] == PPM_ADDR_P2_STYLE) ? (w & PPM_P2_STYLE_WMASK) : w);
            end
        // unmapped place: write lost, read zero
        sfr_write(8'h00, 8'h5A);
        sfr_read(8'h00, 1'b0, d);
        chk_byte(d, 8'h00);
        // output style, analog override and read-back on both ports
        for (int n = 0; n < 12; n++)
        begin
            p = n % 2;
            {lat, sty, dig} = 24'($urandom);
            if (n < 2)
                {lat, sty, dig} = {8'h00, 8'hFF, 8'h0F};
            cfg(p, lat, sty, dig);
            es = p ? (sty & PPM_P2_STYLE_WMASK) : sty;
            eoe = exp_oe(lat, dig, es);
            repeat (6) @(negedge clk);
            chk_byte(p ? p2_oe_n : p1_oe_n, eoe);
            chk_byte((p ? p2_out : p1_out) | eoe, lat | eoe);
            chk_byte(p ? port2_skip : port1_skip, ~dig);
            chk_byte(p ? port2_analog_n : port1_analog_n, dig);
            sfr_read(p ? PPM_ADDR_P2_DATA : PPM_ADDR_P1_DATA, 1'b0, d);
            chk_byte(d, dig & (lat | eoe));
            sfr_read(p ? PPM_ADDR_P2_DATA : PPM_ADDR_P1_DATA, 1'b1, d);
            chk_byte(d, lat);
        end
        // all pins released so the outside world drives them
        dig1 = 8'($urandom);
        cfg(1, 8'hFF, 8'h00, dig1);
        cfg(0, 8'hFF, 8'h00, 8'hFF);
        @(negedge clk);
        {ext1_en, ext2_en} = 16'hFFFF;
        repeat (6) @(negedge clk);
        for (int n = 0; n < 16; n++)
        begin
            {mask, val, dig} = 24'($urandom);
            if (n == 0)
                mask = 8'h00;
            if (n == 1)
                {mask, val, dig} = {8'hFF, ext1, 8'hFF};
            sfr_write(PPM_ADDR_P1_MASK, mask);
            sfr_write(PPM_ADDR_P1_VALUE, val);
            sfr_write(PPM_ADDR_P1_ANALOG, dig);
            match_irq_enable = 1'($urandom);
            prev = ext2;
            if (n > 1)
                {ext1, ext2} = 16'($urandom);
            sfr_read(PPM_ADDR_P2_DATA, 1'b0, d);
            chk_byte(d, prev & dig1);
            repeat (6) @(negedge clk);
            sfr_read(PPM_ADDR_P2_DATA, 1'b0, d);
            chk_byte(d, ext2 & dig1);
            sfr_read(PPM_ADDR_P2_DATA, 1'b1, d);
            chk_byte(d, 8'hFF);
            em = ((ext1 & dig & mask) != (val & mask));
            chk_bit(match_event, em);
            chk_bit(match_irq, em & match_irq_enable);
            chk_bit(osc_wake, em);
        end
        // second reset in mid-run with pins still driven from outside
        do_reset();
        print_verdict();
    end
endmodule : ppm_port_tb
`default_nettype wire
